// ==== verilog/flash_ctrl_pkg.sv ====
// Purpose: shared constants and types for the flash program/erase control block
// Assumes: 16-bit bus address, byte-addressed control registers
// Notes: bit positions inside the four control bytes are fixed here
package flash_ctrl_pkg;

	// control register block, four bytes from the reset base
	localparam logic [15:0] REG_BASE = 16'h00f4;
	localparam logic [1:0] REG_CONFIG_LOCK = 2'h0;
	localparam logic [1:0] REG_MODULE_CONFIG = 2'h1;
	localparam logic [1:0] REG_MODULE_TEST = 2'h2;
	localparam logic [1:0] REG_PROGRAM_CONTROL = 2'h3;

	// array decode after reset in single-chip mode (upper half of the map)
	localparam logic ARRAY_TOP_BIT = 1'h1;
	// boot block: top 2 Kbyte of the 32 Kbyte array, offset bits 14:11 all set
	localparam logic [3:0] BOOT_OFFSET_TAG = 4'hf;

	// config_lock fields
	localparam int LOCK_BIT = 0;
	// module_config fields
	localparam int BOOT_GUARD_BIT = 0;
	// module_test fields
	localparam int STRESS_TEST_ON_BIT = 7;
	localparam int GATE_OR_DRAIN_PICK_BIT = 6;
	localparam int STRESS_HV_SEEN_BIT = 5;
	localparam int LOW_VOLT_REF_ENABLE_BIT = 4;
	localparam int SUPPLY_LOCK_OVERRIDE_BIT = 3;
	localparam int THRESHOLD_CHECK_ENABLE_BIT = 2;
	localparam int SPARE_ROW_SELECT_BIT = 1;
	localparam int DUAL_WORD_PROGRAM_BIT = 0;
	// writable test bits; the stress status bit is driven by the array
	localparam logic [7:0] TEST_WRITE_MASK = 8'hdf;
	// program_control fields
	localparam int HALT_IN_WAIT_BIT = 4;
	localparam int SUPPLY_OK_STATUS_BIT = 3;
	localparam int BULK_WIPE_SELECT_BIT = 2;
	localparam int CAPTURE_ARM_BIT = 1;
	localparam int HIGH_VOLTAGE_APPLY_BIT = 0;

	// reset values
	localparam logic BOOT_GUARD_RESET = 1'h1;
	localparam logic [7:0] TEST_RESET = 8'h00;
	localparam logic [15:0] ZERO_WORD = 16'h0000;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// bus access sequencer
	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_READ_WAIT,
		BUS_READ_TAIL
	} bus_state_t;

endpackage

// ==== verilog/flash_program_erase_ctrl.sv ====
// Purpose: read path, programming latches and program/erase interlocks of a flash array
// Assumes: one CPU request at a time, held off until bus_ack_o; inputs synchronous to clk_i
// Notes: pulse timing and verification are left to software; array answers within the cycle of its fetch strobe
//
// How it works
// - 16-bit array, misaligned word reads take two fetches
// - program one byte or word; erase whole array
// - top 2 Kbyte boot block is guarded
// - array decodes high half only in single-chip mode
// - four control bytes at fixed base address
// - lock bit writable once per reset normally
// - lock set blocks module configuration writes
// - boot guard frozen by lock or high voltage
// - guarded boot block never erased, guard checked for program at capture only
// - normal mode ignores test bits, reads zero
// - low supply refuses arming unless override set
// - dual word ignores low address bits, two words
// - spare row replaces array rows in special mode
// - halt bit stops module clock in wait
// - read-only supply level status bit
// - erase select changeable only with voltage off
// - armed latches capture next valid array write
// - voltage enable needs arm and captured latches
// - voltage on freezes boot guard and control bits but its own; lock and test bits stay writable
// - enable with arm cleared does nothing
// - read result chosen by enable, arm, erase
// - registers stay accessible while voltage applied
// - after capture, further array writes ignored
// - array writes discarded outside programming sequence
`timescale 1ns/1ps
module flash_program_erase_ctrl
	import flash_ctrl_pkg::*;
#(
	parameter int ARR_AW = 14, // array word address width (32 Kbyte)
	parameter int BOOT_AW = 10 // boot block word address width (2 Kbyte)
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic special_mode_i,
	input wire logic single_chip_i,
	input wire logic wait_mode_i,
	input wire logic program_supply_pin_i,
	input wire logic stress_hv_seen_i,
	input wire logic [15:0] bus_addr_i,
	input wire logic [15:0] bus_wdata_i,
	input wire logic bus_rd_i,
	input wire logic bus_wr_i,
	input wire logic bus_byte_i,
	input wire logic [15:0] arr_rdata_i,
	output logic [15:0] bus_rdata_o,
	output logic bus_ack_o,
	output logic arr_rd_o,
	output logic [ARR_AW-1:0] arr_addr_o,
	output logic spare_row_o,
	output logic [ARR_AW-1:0] prog_addr_o,
	output logic [15:0] prog_data_o,
	output logic [1:0] prog_lanes_o,
	output logic dual_word_o,
	output logic prog_pulse_o,
	output logic erase_pulse_o,
	output logic erase_boot_o,
	output logic module_clk_en_o,
	output logic stress_test_on_o,
	output logic gate_or_drain_pick_o,
	output logic low_volt_ref_enable_o,
	output logic threshold_check_enable_o
);

	// the decode below assumes a 32 Kbyte array holding a smaller boot block
	generate
		if (ARR_AW != 14 || BOOT_AW < 1 || BOOT_AW >= ARR_AW) begin : g_bad_size
			$error("unsupported array or boot block size");
		end
	endgenerate

	localparam int OFF_W = ARR_AW + 1; // byte offset width inside the array

	// complete state of the block
	typedef struct packed {
		bus_state_t bst; // access sequencer
		logic lock; // configuration lock
		logic lock_done; // lock already written since reset
		logic boot_guard; // boot block guard
		logic [7:0] test; // test bits as written
		logic halt_wait; // stop module clock in wait
		logic bulk_wipe_select; // bulk wipe select
		logic lat; // capture arm
		logic high_voltage_apply; // high voltage apply
		logic captured; // latches hold address and data
		logic [ARR_AW-1:0] lat_addr; // latched word address
		logic [15:0] lat_data; // latched data
		logic [1:0] lat_lanes; // latched byte lanes, bit 1 = even byte
		logic lat_dual; // latched with dual word programming
		logic lat_boot; // latched address lies in boot block
		logic rd_byte; // pending read is a byte read
		logic rd_odd; // pending read starts at odd address
		logic rd_mis; // pending read is misaligned word
		logic [7:0] hi_byte; // first half of a misaligned word
		logic ack; // answer strobe
		logic [15:0] rdata; // answer data
		logic arr_rd; // array fetch strobe
		logic [ARR_AW-1:0] arr_addr; // array fetch address
		logic spare; // spare row decode
		logic prog; // programming voltage to one location
		logic erase; // erase voltage to whole array
		logic erase_boot; // erase includes boot block
		logic clk_en; // module clock enable
		logic [3:0] test_out; // test controls gated by special mode
	} state_t;

	state_t s_r; // registered state
	state_t s_nxt; // next state

	// next-state logic for the whole block
	always_comb begin
		logic [15:0] lane_addr;
		logic [7:0] wb;
		logic [7:0] rb;
		logic [1:0] idx;
		logic reg_hit;
		logic arr_hit;
		logic [OFF_W-1:0] off;
		logic in_boot;
		logic misaligned;
		logic arm_ok;
		logic [ARR_AW-1:0] cap_addr;
		logic [15:0] rd_acc;
		lane_addr = ZERO_WORD;
		wb = ZERO_BYTE;
		rb = ZERO_BYTE;
		idx = REG_CONFIG_LOCK;
		reg_hit = 1'b0;
		rd_acc = ZERO_WORD;
		off = bus_addr_i[OFF_W-1:0];
		// array seen only in single-chip mode, upper half of the map
		arr_hit = single_chip_i && (bus_addr_i[15] == ARRAY_TOP_BIT);
		in_boot = (off[OFF_W-1:OFF_W-4] == BOOT_OFFSET_TAG);
		misaligned = !bus_byte_i && off[0];
		// a low supply refuses arming unless the override test bit is set
		arm_ok = program_supply_pin_i ||
			(special_mode_i && s_r.test[SUPPLY_LOCK_OVERRIDE_BIT]);
		cap_addr = off[OFF_W-1:1];
		s_nxt = s_r;
		s_nxt.ack = 1'b0;
		s_nxt.arr_rd = 1'b0;

		case (s_r.bst)
			BUS_IDLE: begin
				// control bytes, one or two lanes per access
				for (int k = 0; k < 2; k++) begin
					lane_addr = bus_addr_i + 16'(k);
					idx = lane_addr[1:0];
					wb = (bus_byte_i || k == 1) ? bus_wdata_i[7:0] : bus_wdata_i[15:8];
					if ((k == 0 || !bus_byte_i) &&
						lane_addr[15:2] == REG_BASE[15:2] && (bus_rd_i || bus_wr_i)) begin
						reg_hit = 1'b1;
						rb = ZERO_BYTE;
						case (idx)
							REG_CONFIG_LOCK: begin
								rb[LOCK_BIT] = s_r.lock;
								// once per reset in normal modes, anytime in special
								if (bus_wr_i && (special_mode_i || !s_r.lock_done)) begin
									s_nxt.lock = wb[LOCK_BIT];
									s_nxt.lock_done = 1'b1;
								end
							end
							REG_MODULE_CONFIG: begin
								rb[BOOT_GUARD_BIT] = s_r.boot_guard;
								// lock blocks the register, voltage freezes the guard
								if (bus_wr_i && !s_r.lock && !s_r.high_voltage_apply) begin
									s_nxt.boot_guard = wb[BOOT_GUARD_BIT];
								end
							end
							REG_MODULE_TEST: begin
								// test bits only exist in special mode
								if (special_mode_i) begin
									rb = s_r.test;
									rb[STRESS_HV_SEEN_BIT] = stress_hv_seen_i;
									if (bus_wr_i) begin
										s_nxt.test = wb & TEST_WRITE_MASK;
									end
								end
							end
							default: begin
								rb[HALT_IN_WAIT_BIT] = s_r.halt_wait;
								rb[SUPPLY_OK_STATUS_BIT] = program_supply_pin_i;
								rb[BULK_WIPE_SELECT_BIT] = s_r.bulk_wipe_select;
								rb[CAPTURE_ARM_BIT] = s_r.lat;
								rb[HIGH_VOLTAGE_APPLY_BIT] = s_r.high_voltage_apply;
								if (bus_wr_i && s_r.high_voltage_apply) begin
									// only the voltage bit moves while it is on
									s_nxt.high_voltage_apply = wb[HIGH_VOLTAGE_APPLY_BIT];
								end else if (bus_wr_i) begin
									s_nxt.halt_wait = wb[HALT_IN_WAIT_BIT];
									s_nxt.bulk_wipe_select = wb[BULK_WIPE_SELECT_BIT];
									// arming refused on a low supply
									if (!wb[CAPTURE_ARM_BIT] || s_r.lat || arm_ok) begin
										s_nxt.lat = wb[CAPTURE_ARM_BIT];
									end
									if (!s_nxt.lat) begin
										s_nxt.captured = 1'b0;
									end
									// needs arm already set, latches filled, arm kept
									s_nxt.high_voltage_apply = wb[HIGH_VOLTAGE_APPLY_BIT] && s_r.lat &&
										s_r.captured && s_nxt.lat;
								end
							end
						endcase
						if (bus_byte_i) begin
							rd_acc[7:0] = rb;
						end else if (k == 0) begin
							rd_acc[15:8] = rb;
						end else begin
							rd_acc[7:0] = rb;
						end
					end
				end
				if (reg_hit) begin
					s_nxt.ack = 1'b1;
					s_nxt.rdata = rd_acc;
				end else if (arr_hit && bus_wr_i) begin
					s_nxt.ack = 1'b1;
					// first valid write after arming fills the latches
					// a guarded boot address is not captured unless bulk wipe is selected
					if (s_r.lat && !s_r.captured && !s_r.high_voltage_apply && !misaligned &&
						!(s_r.boot_guard && in_boot && !s_r.bulk_wipe_select)) begin
						s_nxt.captured = 1'b1;
						s_nxt.lat_boot = in_boot;
						s_nxt.lat_dual = special_mode_i && s_r.test[DUAL_WORD_PROGRAM_BIT];
						if (s_nxt.lat_dual) begin
							// low address bits dropped, word goes to both words
							cap_addr[0] = 1'b0;
						end
						s_nxt.lat_addr = cap_addr;
						// one byte or one aligned word per operation
						if (bus_byte_i && !s_nxt.lat_dual) begin
							s_nxt.lat_lanes = off[0] ? 2'h1 : 2'h2;
							s_nxt.lat_data = {bus_wdata_i[7:0], bus_wdata_i[7:0]};
						end else begin
							s_nxt.lat_lanes = 2'h3;
							s_nxt.lat_data = bus_wdata_i;
						end
					end
				end else if (arr_hit && bus_rd_i) begin
					if (s_r.high_voltage_apply) begin
						// read ignored while voltage applied
						s_nxt.ack = 1'b1;
						s_nxt.rdata = ZERO_WORD;
					end else begin
						s_nxt.arr_rd = 1'b1;
						s_nxt.rd_byte = bus_byte_i;
						s_nxt.rd_odd = off[0];
						s_nxt.bst = BUS_READ_WAIT;
						if (s_r.lat && !s_r.bulk_wipe_select && s_r.captured) begin
							// armed for programming: location being programmed
							s_nxt.arr_addr = s_r.lat_addr;
							s_nxt.rd_mis = 1'b0;
						end else begin
							s_nxt.arr_addr = off[OFF_W-1:1];
							s_nxt.rd_mis = misaligned;
						end
					end
				end
			end
			BUS_READ_WAIT: begin
				if (s_r.rd_mis) begin
					// second fetch for the trailing byte
					s_nxt.hi_byte = arr_rdata_i[7:0];
					s_nxt.arr_addr = s_r.arr_addr + {{(ARR_AW-1){1'b0}}, 1'b1};
					s_nxt.arr_rd = 1'b1;
					s_nxt.bst = BUS_READ_TAIL;
				end else begin
					s_nxt.ack = 1'b1;
					s_nxt.bst = BUS_IDLE;
					if (!s_r.rd_byte) begin
						s_nxt.rdata = arr_rdata_i;
					end else if (s_r.rd_odd) begin
						s_nxt.rdata = {ZERO_BYTE, arr_rdata_i[7:0]};
					end else begin
						s_nxt.rdata = {ZERO_BYTE, arr_rdata_i[15:8]};
					end
				end
			end
			BUS_READ_TAIL: begin
				s_nxt.ack = 1'b1;
				s_nxt.rdata = {s_r.hi_byte, arr_rdata_i[15:8]};
				s_nxt.bst = BUS_IDLE;
			end
			default: begin
				s_nxt.bst = BUS_IDLE;
			end
		endcase

		// test controls only take effect in special mode
		if (!special_mode_i) begin
			s_nxt.test = TEST_RESET;
		end
		s_nxt.spare = special_mode_i && s_nxt.test[SPARE_ROW_SELECT_BIT];
		s_nxt.test_out = {s_nxt.test[STRESS_TEST_ON_BIT], s_nxt.test[GATE_OR_DRAIN_PICK_BIT],
			s_nxt.test[LOW_VOLT_REF_ENABLE_BIT], s_nxt.test[THRESHOLD_CHECK_ENABLE_BIT]};
		// voltage reaches the array only with arm held and latches filled
		s_nxt.prog = s_nxt.high_voltage_apply && s_nxt.lat && s_nxt.captured && !s_nxt.bulk_wipe_select;
		s_nxt.erase = s_nxt.high_voltage_apply && s_nxt.lat && s_nxt.captured && s_nxt.bulk_wipe_select;
		// boot block joins the erase only when unguarded; a program checks the guard only at capture
		s_nxt.erase_boot = s_nxt.erase && !s_nxt.boot_guard;
		s_nxt.clk_en = !(wait_mode_i && s_nxt.halt_wait);
	end

	// one register stage for all state, frozen while ce_i is low
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			s_r <= '0;
			s_r.bst <= BUS_IDLE;
			// nothing armed after reset
			s_r.boot_guard <= BOOT_GUARD_RESET;
			s_r.test <= TEST_RESET;
			s_r.clk_en <= 1'b1;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	// every output comes straight from the state register
	assign bus_rdata_o = s_r.rdata;
	assign bus_ack_o = s_r.ack;
	assign arr_rd_o = s_r.arr_rd;
	assign arr_addr_o = s_r.arr_addr;
	assign spare_row_o = s_r.spare;
	assign prog_addr_o = s_r.lat_addr;
	assign prog_data_o = s_r.lat_data;
	assign prog_lanes_o = s_r.lat_lanes;
	assign dual_word_o = s_r.lat_dual;
	assign prog_pulse_o = s_r.prog;
	assign erase_pulse_o = s_r.erase;
	assign erase_boot_o = s_r.erase_boot;
	assign module_clk_en_o = s_r.clk_en;
	assign stress_test_on_o = s_r.test_out[3];
	assign gate_or_drain_pick_o = s_r.test_out[2];
	assign low_volt_ref_enable_o = s_r.test_out[1];
	assign threshold_check_enable_o = s_r.test_out[0];

endmodule

// ==== test/flash_ctrl_properties.sv ====
// Purpose: port-level timing and interlock checks of the flash control block
// Assumes: ce_i held high, strobes dropped for an edge between transfers
// Notes: bound to every instance of the control block
`timescale 1ns/1ps
module flash_ctrl_properties #(
	parameter int ARR_AW = 14 // word address width of the array
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic special_mode_i,
	input wire logic wait_mode_i,
	input wire logic [15:0] bus_addr_i,
	input wire logic [15:0] bus_wdata_i,
	input wire logic bus_rd_i,
	input wire logic bus_wr_i,
	input wire logic bus_ack_o,
	input wire logic arr_rd_o,
	input wire logic [ARR_AW-1:0] arr_addr_o,
	input wire logic [ARR_AW-1:0] prog_addr_o,
	input wire logic spare_row_o,
	input wire logic stress_test_on_o,
	input wire logic prog_pulse_o,
	input wire logic erase_pulse_o,
	input wire logic erase_boot_o,
	input wire logic module_clk_en_o
);
	logic [15:0] addr_q; // bus address one edge back
	logic [15:0] wd_q; // write data one edge back
	logic wr_q; // write strobe one edge back
	// plain delay stages; only looked at after a rise, so no reset needed
	always_ff @(posedge clk_i) begin
		addr_q <= bus_addr_i;
		wd_q <= bus_wdata_i;
		wr_q <= bus_wr_i;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// fresh request to the control byte block
	sequence reg_req;
		$rose(bus_rd_i || bus_wr_i) && bus_addr_i[15:2] == 14'h003d;
	endsequence
	// program_control write seen one edge back
	sequence ctl_wr;
		wr_q && addr_q == 16'h00f7;
	endsequence
	a_reg_ack_time: assert property (reg_req |-> ##1 bus_ack_o)
		else $error("register access not answered in one cycle");
	a_read_ack_time: assert property (arr_rd_o |-> ##[1:2] bus_ack_o)
		else $error("array read answer late");
	// an armed, filled latch redirects the fetch to the word being programmed, unless bulk wipe is selected
	a_fetch_addr_match: assert property ($rose(arr_rd_o) |->
		arr_addr_o == addr_q[ARR_AW:1] || arr_addr_o == prog_addr_o)
		else $error("array fetch address differs from bus address");
	a_prog_cause: assert property ($rose(prog_pulse_o) |-> ctl_wr ##0 wd_q[2:0] == 3'h3)
		else $error("program voltage without arming write");
	a_erase_cause: assert property ($rose(erase_pulse_o) |-> ctl_wr ##0 wd_q[2:0] == 3'h7)
		else $error("erase voltage without arming write");
	a_pulse_exclusive: assert property (!(prog_pulse_o && erase_pulse_o) && (!erase_boot_o || erase_pulse_o))
		else $error("program and erase together");
	a_clock_runs: assert property (!wait_mode_i [*2] |-> module_clk_en_o)
		else $error("module clock stopped outside wait");
	a_test_off_normal: assert property (!special_mode_i [*2] |-> !(stress_test_on_o || spare_row_o))
		else $error("test function active in normal mode");
endmodule
bind flash_program_erase_ctrl flash_ctrl_properties #(.ARR_AW(ARR_AW)) props_inst (
	.clk_i, .rstn_i, .special_mode_i, .wait_mode_i, .bus_addr_i, .bus_wdata_i, .bus_rd_i,
	.bus_wr_i, .bus_ack_o, .arr_rd_o, .arr_addr_o, .prog_addr_o, .spare_row_o, .stress_test_on_o,
	.prog_pulse_o, .erase_pulse_o, .erase_boot_o, .module_clk_en_o);

// ==== test/flash_array_model.sv ====
// Purpose: behavioural flash array answering fetches of the control block
// Assumes: the fetched word must stand while the fetch strobe is high
// Notes: contents are a fixed function of the word address, nothing stored
`timescale 1ns/1ps
module flash_array_model (
	input wire logic clk_i,
	input wire logic rd_i,
	input wire logic [13:0] addr_i,
	output logic [15:0] rdata_o
);
	logic [15:0] noise_r = 16'h1234; // junk shown between fetches
	// changes every cycle so a late sample never matches by luck
	always_ff @(posedge clk_i) begin
		noise_r <= ~noise_r ^ 16'h0f0f;
	end
	assign rdata_o = rd_i ? ({2'h0, addr_i} ^ 16'ha5c3) : noise_r;
endmodule

// ==== test/tb.sv ====
// Purpose: self-checking bench for the flash program/erase control block
// Assumes: ce_i high, bus inputs driven on the falling edge
// Notes: expected array words mirror the array model's address function
`timescale 1ns/1ps
module tb;
	logic clk_i, rstn_i, special_mode_i, single_chip_i, wait_mode_i, program_supply_pin_i;
	logic bus_rd_i, bus_wr_i, bus_byte_i, bus_ack_o, arr_rd_o, spare_row_o, dual_word_o;
	logic prog_pulse_o, erase_pulse_o, erase_boot_o, module_clk_en_o, stress_test_on_o;
	logic gate_or_drain_pick_o, low_volt_ref_enable_o, threshold_check_enable_o, got;
	logic [15:0] bus_addr_i, bus_wdata_i, arr_rdata_i, bus_rdata_o, prog_data_o, q, r;
	logic [13:0] arr_addr_o, prog_addr_o;
	logic [1:0] prog_lanes_o;
	int error_cnt = 0, tests_run = 0, cyc = 0;
	wire [4:0] tst = {stress_test_on_o, gate_or_drain_pick_o, low_volt_ref_enable_o,
		threshold_check_enable_o, spare_row_o}; // test outputs, zero in normal mode
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	flash_program_erase_ctrl flash_program_erase_ctrl_inst (.clk_i, .rstn_i, .ce_i(1'b1),
		.special_mode_i, .single_chip_i, .wait_mode_i, .program_supply_pin_i,
		.stress_hv_seen_i(1'b0), .bus_addr_i, .bus_wdata_i, .bus_rd_i, .bus_wr_i, .bus_byte_i,
		.arr_rdata_i, .bus_rdata_o, .bus_ack_o, .arr_rd_o, .arr_addr_o, .spare_row_o,
		.prog_addr_o, .prog_data_o, .prog_lanes_o, .dual_word_o, .prog_pulse_o,
		.erase_pulse_o, .erase_boot_o, .module_clk_en_o, .stress_test_on_o,
		.gate_or_drain_pick_o, .low_volt_ref_enable_o, .threshold_check_enable_o);
	flash_array_model flash_array_model_inst (.clk_i, .rd_i(arr_rd_o), .addr_i(arr_addr_o),
		.rdata_o(arr_rdata_i));
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// a hang of the answer logic ends the run here
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one transfer; strobe dropped in the answer cycle so it is not taken twice
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic b);
		@(negedge clk_i);
		bus_wr_i = w;
		bus_rd_i = !w;
		bus_addr_i = a;
		bus_wdata_i = d;
		bus_byte_i = b;
		got = 1'b0;
		for (int n = 0; n < 6 && !got; n++) begin
			@(posedge clk_i);
			#1 got = bus_ack_o;
		end
		q = bus_rdata_o;
		@(negedge clk_i);
		bus_wr_i = 1'b0;
		bus_rd_i = 1'b0;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		acc(1'b1, {8'h00, a}, {8'h00, d}, 1'b1);
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		acc(1'b0, {8'h00, a}, 16'h0000, 1'b1);
		chk({8'h00, q[7:0]}, {8'h00, e});
	endtask
	task automatic rst();
		rstn_i = 1'b0;
		repeat (20) @(negedge clk_i);
		rstn_i = 1'b1;
	endtask
	function automatic logic [15:0] aw(input logic [13:0] i);
		return {2'h0, i} ^ 16'ha5c3;
	endfunction
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// byte lands low; a misaligned word spans two array words
	function automatic logic [15:0] exp_rd(input logic [15:0] a, input logic b);
		logic [15:0] w0, w1;
		w0 = aw(a[14:1]);
		w1 = aw(a[14:1] + 14'h0001);
		if (b) return {8'h00, a[0] ? w0[7:0] : w0[15:8]};
		return a[0] ? {w0[7:0], w1[15:8]} : w0;
	endfunction
	initial begin
		{bus_rd_i, bus_wr_i, bus_byte_i, special_mode_i, wait_mode_i} = 5'h00;
		{bus_addr_i, bus_wdata_i} = 32'h0;
		{single_chip_i, program_supply_pin_i} = 2'h3;
		r = 16'h001e;
		rst();
		rreg(8'hf7, 8'h08);
		rreg(8'hf5, 8'h01);
		wreg(8'hf6, 8'hff);
		rreg(8'hf6, 8'h00);
		// random reads of every width and alignment
		repeat (40) begin
			r = lfsr(r);
			acc(1'b0, {1'b1, r[14:0]}, 16'h0000, r[15]);
			chk(r[15] ? {8'h00, q[7:0]} : q, exp_rd({1'b1, r[14:0]}, r[15]));
		end
		acc(1'b1, 16'h8010, r, 1'b0);
		chk({2'h0, prog_addr_o}, 16'h0000);
		// low supply refuses arming unless overridden in special mode
		program_supply_pin_i = 1'b0;
		wreg(8'hf7, 8'h02);
		rreg(8'hf7, 8'h00);
		special_mode_i = 1'b1;
		wreg(8'hf6, 8'h08);
		wreg(8'hf7, 8'h02);
		rreg(8'hf7, 8'h02);
		wreg(8'hf7, 8'h00);
		program_supply_pin_i = 1'b1;
		wreg(8'hf6, 8'hd7);
		rreg(8'hf6, 8'hd7);
		chk({11'h0, tst}, 16'h001f);
		wreg(8'hf7, 8'h02);
		acc(1'b1, 16'h8016, r, 1'b0);
		chk({prog_addr_o, prog_lanes_o}, 16'h002b);
		chk({15'h0, dual_word_o}, 16'h0001);
		wreg(8'hf7, 8'h00);
		wreg(8'hf6, 8'h00);
		special_mode_i = 1'b0;
		chk({11'h0, tst}, 16'h0000);
		// word program: capture, later write ignored, latched read, pulse
		wreg(8'hf7, 8'h02);
		acc(1'b1, 16'h8010, r, 1'b0);
		acc(1'b1, 16'h8020, ~r, 1'b0);
		chk(prog_data_o, r);
		chk({2'h0, prog_addr_o}, 16'h0008);
		acc(1'b0, 16'h8020, 16'h0000, 1'b0);
		chk(q, aw(14'h0008));
		wreg(8'hf7, 8'h03);
		rreg(8'hf7, 8'h0b);
		chk({15'h0, prog_pulse_o}, 16'h0001);
		wreg(8'hf5, 8'h00);
		rreg(8'hf5, 8'h01);
		acc(1'b0, 16'h8010, 16'h0000, 1'b0);
		chk(q, 16'h0000);
		repeat (10) @(negedge clk_i); // pulse length is kept by software
		wreg(8'hf7, 8'h04);
		rreg(8'hf7, 8'h0a);
		wreg(8'hf7, 8'h00);
		// odd byte program: one lane, byte copied into both halves
		wreg(8'hf7, 8'h02);
		acc(1'b1, 16'h8011, r, 1'b1);
		chk({prog_addr_o, prog_lanes_o}, 16'h0021);
		chk(prog_data_o, {r[7:0], r[7:0]});
		wreg(8'hf7, 8'h00);
		// voltage refused before capture, and when the same write drops arming
		wreg(8'hf7, 8'h02);
		wreg(8'hf7, 8'h03);
		rreg(8'hf7, 8'h0a);
		acc(1'b1, 16'h8010, r, 1'b0);
		wreg(8'hf7, 8'h01);
		rreg(8'hf7, 8'h08);
		chk({15'h0, prog_pulse_o}, 16'h0000);
		wreg(8'hf7, 8'h02);
		acc(1'b1, 16'hf900, r, 1'b0);
		wreg(8'hf7, 8'h03);
		rreg(8'hf7, 8'h0a);
		wreg(8'hf7, 8'h00);
		// bulk erase with guarded boot block, then unguarded
		for (int g = 1; g >= 0; g--) begin
			wreg(8'hf5, 8'(g));
			wreg(8'hf7, 8'h06);
			acc(1'b1, 16'h8000, r, 1'b0);
			wreg(8'hf7, 8'h07);
			chk({14'h0, erase_pulse_o, erase_boot_o}, {14'h0, 1'b1, g == 0});
			wreg(8'hf7, 8'h01);
			rreg(8'hf7, 8'h0f);
			wreg(8'hf7, 8'h00);
			acc(1'b0, 16'h8010, 16'h0000, 1'b0);
			chk(q, aw(14'h0008));
			wreg(8'hf7, 8'h00);
		end
		wreg(8'hf7, 8'h10);
		wait_mode_i = 1'b1;
		repeat (2) @(negedge clk_i);
		chk({15'h0, module_clk_en_o}, 16'h0000);
		wait_mode_i = 1'b0;
		wreg(8'hf7, 8'h00);
		single_chip_i = 1'b0;
		acc(1'b0, 16'h8000, 16'h0000, 1'b0);
		chk({15'h0, got}, 16'h0000);
		single_chip_i = 1'b1;
		acc(1'b0, 16'h00f8, 16'h0000, 1'b1);
		chk({15'h0, got}, 16'h0000);
		// lock is write-once until the next reset
		wreg(8'hf4, 8'h01);
		wreg(8'hf4, 8'h00);
		rreg(8'hf4, 8'h01);
		wreg(8'hf5, 8'h01);
		rreg(8'hf5, 8'h00);
		rst();
		rreg(8'hf4, 8'h00);
		final_report();
	end
endmodule
